// ===== logic/serial_in_latched_output_driver.sv
/*
  Ten-stage serial-in shift register with cascade output, strobe-loaded
  latches and a blanking gate in front of the parallel drivers.
  Assumes shift clock, data, strobe and blanking are synchronous to
  core_clk_in and that the shift clock stays well below half its rate.
*/
module serial_in_latched_output_driver
  import sipo_driver_pkg::*;
#(
  parameter int WIDTH = STAGE_COUNT
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // serial interface
  input wire logic shift_clk_in,
  input wire logic serial_data_in,
  output logic cascade_out,
  // latch and output control
  input wire logic strobe_in,
  input wire logic blank_in,
  // parallel drivers
  output logic [WIDTH-1:0] drive_out
);
  // shift clock edge history
  logic shift_clk_d_ff;
  logic shift_rise;

  // shift register stages
  logic [WIDTH-1:0] shift_ff;
  logic [WIDTH-1:0] nxt_shift;
  logic [WIDTH-1:0] stage_src;

  // latch bank
  logic [WIDTH-1:0] latch_ff;
  logic [WIDTH-1:0] nxt_latch;
  latch_mode_t latch_mode;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_clk_d_ff <= EDGE_HIST_RESET_VAL;
    end else begin
      shift_clk_d_ff <= shift_clk_in;
    end
  end

  // the device has no reset pin; reset values here carry no meaning to the host
  // history resets low, matching the idle level of the shift clock
  assign shift_rise = shift_clk_in & ~shift_clk_d_ff;

  // per-stage source: the head takes the pin, every other stage its neighbour
  genvar k;
  generate
    for (k = 0; k < WIDTH; k++) begin : g_stage
      if (k == 0) begin : g_head
        assign stage_src[k] = serial_data_in;
      end else begin : g_tail
        assign stage_src[k] = shift_ff[k-1];
      end
    end
  endgenerate

  always_comb begin
    if (shift_rise) begin
      nxt_shift = stage_src;
    end else begin
      nxt_shift = shift_ff;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_ff <= SHIFT_RESET_VAL;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  assign cascade_out = shift_ff[WIDTH-1];

  always_comb begin
    if (strobe_in) begin
      latch_mode = LATCH_FOLLOW;
    end else begin
      latch_mode = LATCH_HOLD;
    end
  end

  // transparent latch modelled as a follower register: one core cycle late,
  // traded for a flop-only design with no real latches
  always_comb begin
    case (latch_mode)
      LATCH_FOLLOW: begin
        nxt_latch = shift_ff;
      end
      LATCH_HOLD: begin
        // blanking is not looked at here, so it can never disturb storage
        nxt_latch = latch_ff;
      end
      default: begin
        nxt_latch = latch_ff;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      latch_ff <= LATCH_RESET_VAL;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  output_stage #(
    .WIDTH(WIDTH)
  ) u_output_stage (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .blank_in(blank_in),
    .latch_in(latch_ff),
    .drive_out(drive_out)
  );
endmodule

// ===== inc/sipo_driver_pkg.sv
/*
  Shared constants for the serial-in latched output driver.
  Assumes a single 50 MHz core clock and synchronous pin inputs.
*/
package sipo_driver_pkg;
  localparam int STAGE_COUNT = 10;
  localparam int CORE_CLK_HZ = 50000000;
  localparam int SHIFT_CLK_PLAN_HZ = 10000000;
  // fewest core cycles per shift clock half period at the planned rate
  localparam int SHIFT_HALF_CYCLES = CORE_CLK_HZ / (2 * SHIFT_CLK_PLAN_HZ);
  localparam logic [STAGE_COUNT-1:0] SHIFT_RESET_VAL = 10'h000;
  localparam logic [STAGE_COUNT-1:0] LATCH_RESET_VAL = 10'h000;
  localparam logic EDGE_HIST_RESET_VAL = 1'b0;
  typedef enum logic [1:0] {
    LATCH_HOLD = 2'b01,
    LATCH_FOLLOW = 2'b10
  } latch_mode_t;
endpackage

// ===== logic/output_stage.sv
/*
  Output stage: one driver per latch, forced low while blanking is high.
  Assumes latch values arrive from flip-flops in the parent.
*/
module output_stage
  import sipo_driver_pkg::*;
#(
  parameter int WIDTH = STAGE_COUNT
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // control and data
  input wire logic blank_in,
  input wire logic [WIDTH-1:0] latch_in,
  // pins
  output logic [WIDTH-1:0] drive_out
);
  logic [WIDTH-1:0] drive_ff;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_drv
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          drive_ff[i] <= 1'b0;
        end else begin
          // blanking only gates the driver, latch storage is untouched
          drive_ff[i] <= blank_in ? 1'b0 : latch_in[i];
        end
      end
    end
  endgenerate

  assign drive_out = drive_ff;
endmodule

// ===== bench/sipo_chk.sv
/* pin checker for the driver, bound below; assumes one core clock */
module sipo_chk #(parameter int WIDTH = 10) (input wire logic core_clk_in, nrst_in,
  shift_clk_in, serial_data_in, cascade_out, strobe_in, blank_in,
  input wire logic [WIDTH-1:0] drive_out);
  timeunit 1ns;
  timeprecision 1ns;
  logic p_ff;
  wire r = shift_clk_in && !p_ff, s = strobe_in, b = blank_in, c = cascade_out;
  wire i = serial_data_in;
  wire [WIDTH-1:0] d = drive_out;
  // no reset: the bench holds the shift clock low through reset
  always_ff @(posedge core_clk_in) p_ff <= shift_clk_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_cas_hold: assert property (!r |=> $stable(c)) else $error("cascade moved");
  a_cas_shift: assert property (r && s ##1 !b |=> $past(c) == d[WIDTH-2]) else $error("sh");
  a_blank_low: assert property (b |=> d == '0) else $error("not blanked");
  a_latch_hold: assert property (!s && !b ##1 !b |=> $stable(d)) else $error("hold");
  a_latch_copy: assert property (s ##1 !b |=> d[WIDTH-1] == $past(c, 2)) else $error("cp");
  a_bit_take: assert property (r ##1 s ##1 !b |=> d[0] == $past(i, 3)) else $error("in");
  a_bit_move: assert property (r && s ##1 s && !b ##1 !b |=> d[WIDTH-1:1] == $past(d[WIDTH-2:0]))
    else $error("move");
  a_blank_keep: assert property ((!s && !b)[*2] ##1 b && !s ##1 !b |=> d == $past(d, 3))
    else $error("latch lost");
  c_shift: cover property (r);
  c_load: cover property (s ##1 !s);
  c_blank: cover property (b ##1 !b);
endmodule
bind serial_in_latched_output_driver sipo_chk #(.WIDTH(WIDTH)) u_chk (.core_clk_in, .nrst_in,
  .shift_clk_in, .serial_data_in, .cascade_out, .strobe_in, .blank_in, .drive_out);

// ===== bench/host_model.sv
/* host model: shifts a word out first bit highest at 10 MHz; called by the bench */
module host_model (input wire logic core_clk_in, output logic sclk_out = 1'b0,
  output logic sdat_out = 1'b0);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic send(input logic [9:0] w);
    for (int k = 9; k >= 0; k--) begin
      sclk_out <= 1'b0;
      sdat_out <= w[k];
      repeat (3) @(posedge core_clk_in);
      sclk_out <= 1'b1;
      repeat (2) @(posedge core_clk_in);
    end
    sclk_out <= 1'b0;
    sdat_out <= ~w[0];
  endtask
endmodule

// ===== bench/serial_in_latched_output_driver_tb.sv
/* bench: host model shifts words, tasks strobe, blank and check the pins */
module serial_in_latched_output_driver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, sc, sd, stb = 1'b0, blk = 1'b0, cas;
  logic [9:0] drv;
  int miscompares = 0, num_checks = 0;
  initial forever #10 clk = ~clk;
  host_model u_host (.core_clk_in(clk), .sclk_out(sc), .sdat_out(sd));
  serial_in_latched_output_driver u_dut (.core_clk_in(clk), .nrst_in(nrst), .shift_clk_in(sc),
    .serial_data_in(sd), .cascade_out(cas), .strobe_in(stb), .blank_in(blk), .drive_out(drv));
  // step past the edge so registered outputs have landed
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string n, input logic [9:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task t_latch;
    u_host.send(10'h2d5);
    w(3);
    chk("held", drv, 10'h000);
    chk("cascade", {9'h000, cas}, 10'h001);
    stb <= 1'b1;
    w(1);
    stb <= 1'b0;
    w(3);
    chk("load", drv, 10'h2d5);
  endtask
  task t_blank;
    u_host.send(10'h0f0);
    w(3);
    chk("hold", drv, 10'h2d5);
    chk("cascade2", {9'h000, cas}, 10'h000);
    blk <= 1'b1;
    w(1);
    chk("blank", drv, 10'h000);
    blk <= 1'b0;
    w(2);
    chk("unblank", drv, 10'h2d5);
  endtask
  task t_follow;
    blk <= 1'b1;
    stb <= 1'b1;
    u_host.send(10'h12a);
    w(0);
    chk("entry", drv, 10'h000);
    blk <= 1'b0;
    w(3);
    chk("follow", drv, 10'h12a);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    w(5);
    nrst <= 1'b1;
    t_latch;
    t_blank;
    t_follow;
    summarize;
  end
  // about three times the expected run
  initial begin
    #10000;
    miscompares++;
    summarize;
  end
endmodule
